/* File: nfr_host_model.sv */
// nfr_host_model: host serial controller issuing feature commands
// assumes: mode 0 link, bench clock 4 ns, sclk 160 ns, driven at negedge
`timescale 1ns/1ps
module nfr_host_model
   import nfr_pkg::*;
(
   // clock
   input wire logic i_clock,
   // serial link
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso,
   input wire logic i_miso_oe
);
   localparam int HALF = 20;

   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clock);
   endtask

   // one byte msb first; miso taken just before the rise
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx,
         output logic oe_all);
      oe_all = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i];
         wait_clk(HALF);
         rx[i] = i_miso;
         oe_all = oe_all & i_miso_oe;
         o_sclk = 1'b1;
         wait_clk(HALF);
         o_sclk = 1'b0;
      end
   endtask

   // opcode, address, one data byte; reset opcode stands alone
   task automatic frame(input logic [7:0] op, input logic [7:0] addr,
         input logic [7:0] wdata, output logic [7:0] rdata,
         output logic oe_ok);
      logic [7:0] dummy;
      logic oe_x;
      rdata = 8'h00;
      oe_ok = 1'b0;
      o_cs_n = 1'b0;
      wait_clk(HALF);
      shift(op, dummy, oe_x);
      if (op != NFR_OP_RESET) begin
         shift(addr, dummy, oe_x);
         shift(wdata, rdata, oe_ok);
      end
      wait_clk(HALF);
      o_cs_n = 1'b1;
      // released line: no stale level left behind
      o_mosi = ~o_mosi;
      wait_clk(HALF);
   endtask
endmodule

/* File: nfr_pkg.sv */
// nfr_pkg: constants and carrier types for the feature register bank
// assumes: one 250 MHz clock domain, serial link sampled as plain inputs
package nfr_pkg;
   // command opcodes
   localparam logic [7:0] NFR_OP_GET = 8'h0F;
   localparam logic [7:0] NFR_OP_SET = 8'h1F;
   localparam logic [7:0] NFR_OP_RESET = 8'hFF;
   localparam logic [7:0] NFR_OP_PROGRAM = 8'h10;
   localparam logic [7:0] NFR_OP_ERASE = 8'hD8;
   // register addresses
   localparam logic [7:0] NFR_ADDR_SEC0 = 8'h80;
   localparam logic [7:0] NFR_ADDR_SEC1 = 8'h84;
   localparam logic [7:0] NFR_ADDR_SEC2 = 8'h88;
   localparam logic [7:0] NFR_ADDR_SEC3 = 8'h8C;
   localparam logic [7:0] NFR_ADDR_PROT = 8'hA0;
   localparam logic [7:0] NFR_ADDR_CONF = 8'hB0;
   localparam logic [7:0] NFR_ADDR_STAT = 8'hC0;
   // protection register fields
   localparam int NFR_PR_LOCK = 0;
   localparam int NFR_PR_TB = 2;
   localparam int NFR_PR_LVL = 3;
   localparam int NFR_PR_GATE = 7;
   localparam logic [7:0] NFR_PR_WMASK = 8'hFD;
   localparam logic [7:0] NFR_PR_RESET = 8'h7C;
   // configuration register fields
   localparam int NFR_CF_QE = 0;
   localparam int NFR_CF_DRV = 1;
   localparam int NFR_CF_ECC = 4;
   localparam int NFR_CF_OTPE = 6;
   localparam int NFR_CF_OTPL = 7;
   localparam logic [7:0] NFR_CF_WMASK = 8'hD7;
   localparam logic [7:0] NFR_CF_RESET = 8'h10;
   // status register fields
   localparam int NFR_ST_OIP = 0;
   localparam int NFR_ST_WEL = 1;
   localparam int NFR_ST_EFAIL = 2;
   localparam int NFR_ST_PFAIL = 3;
   localparam int NFR_ST_ECCS = 4;
   // array geometry
   localparam int NFR_BLOCK_BITS = 11;
   localparam int NFR_LVL_BITS = 4;
   // reset busy time
   localparam int NFR_CLK_MHZ = 250;
   localparam int NFR_RESET_BUSY_NS = 400;
   localparam int NFR_RESET_BUSY_CYC = (NFR_RESET_BUSY_NS * NFR_CLK_MHZ) / 1000;

   typedef struct packed {
      logic [3:0] count;
   } nfr_ecc_t;

   typedef struct packed {
      logic [1:0] summary;
      nfr_ecc_t [3:0] sector;
   } nfr_ecc_result_t;

   typedef struct packed {
      logic valid;
      logic is_erase;
      logic [NFR_BLOCK_BITS-1:0] block;
   } nfr_array_req_t;
endpackage

/* File: nfr_regs.sv */
// nfr_regs: feature register bank and block protection of a serial nand
// assumes: spi mode 0, link pins sampled by i_clock, host keeps busy rule
`timescale 1ns/1ps
module nfr_regs
   import nfr_pkg::*;
#(
   parameter int RESET_BUSY_CYC = NFR_RESET_BUSY_CYC
) (
   // clock and reset (power-on)
   input wire logic i_clock,
   input wire logic i_rst_n,
   // serial link
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic i_wp_n,
   output logic o_miso,
   output logic o_miso_oe,
   // straps and ecc engine
   input wire logic i_otp_locked,
   input wire nfr_ecc_result_t i_ecc_boot,
   // array command check
   input wire nfr_array_req_t i_array_req,
   output logic o_array_accept,
   output logic o_array_reject,
   // state view
   output logic [7:0] o_protection,
   output logic [7:0] o_configuration,
   output logic o_busy
);
   typedef enum logic [2:0] {
      NFR_S_BOOT, NFR_S_IDLE, NFR_S_OP, NFR_S_ADDR, NFR_S_DATA, NFR_S_SKIP
   } nfr_state_t;
   logic sclk_s, cs_n_s, mosi_s, wp_n_s;
   nfr_sync u_sclk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_sclk),
      .o_level(sclk_s));
   nfr_sync #(.IDLE_LEVEL(1'b1)) u_cs (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_pin(i_cs_n), .o_level(cs_n_s));
   nfr_sync u_mosi (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_mosi),
      .o_level(mosi_s));
   nfr_sync #(.IDLE_LEVEL(1'b1)) u_wp (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_pin(i_wp_n), .o_level(wp_n_s));
   nfr_state_t st_q, st_d;
   logic sclk_q, sclk_d, miso_q, miso_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, op_q, op_d, addr_q, addr_d, tx_q, tx_d;
   logic [7:0] prot_q, prot_d, conf_q, conf_d, stat_q, stat_d;
   nfr_ecc_t [3:0] sec_q, sec_d;
   logic [15:0] busy_q, busy_d;
   logic acc_q, acc_d, rej_q, rej_d;
   logic rise, fall, prot_wr_ok;
   logic [7:0] byte_in, rd_val;
   logic [NFR_LVL_BITS-1:0] lvl;
   logic [NFR_BLOCK_BITS:0] span;
   logic hit;
   assign rise = sclk_s && !sclk_q;
   assign fall = !sclk_s && sclk_q;
   assign byte_in = {sh_q[6:0], mosi_s};
   assign lvl = prot_q[NFR_PR_LVL +: NFR_LVL_BITS];
   // protection register write permission
   always_comb begin
      if (prot_q[NFR_PR_LOCK]) begin
         prot_wr_ok = 1'b0;
      end else if (conf_q[NFR_CF_QE]) begin
         prot_wr_ok = 1'b1;
      end else begin
         prot_wr_ok = !prot_q[NFR_PR_GATE] || wp_n_s;
      end
   end
   // protected span from the level code
   always_comb begin
      span = '0;
      if (lvl[3:2] == 2'b11) begin
         span = (NFR_BLOCK_BITS+1)'(1) << NFR_BLOCK_BITS;
      end else if (lvl != 4'h0) begin
         span = (NFR_BLOCK_BITS+1)'(1) << (lvl - 4'h1);
      end
   end
   // bottom span counts up from block 0, top span down from the last
   assign hit = prot_q[NFR_PR_TB] ? ({1'b0, i_array_req.block} < span) :
      (({1'b0, i_array_req.block} + span) >
      (((NFR_BLOCK_BITS+1)'(1) << NFR_BLOCK_BITS) - 1'b1));
   always_comb begin
      case (addr_q)
         NFR_ADDR_PROT: rd_val = prot_q & NFR_PR_WMASK;
         NFR_ADDR_CONF: rd_val = conf_q & NFR_CF_WMASK;
         NFR_ADDR_STAT: rd_val = stat_q;
         NFR_ADDR_SEC0: rd_val = {4'h0, sec_q[0].count};
         NFR_ADDR_SEC1: rd_val = {4'h1, sec_q[1].count};
         NFR_ADDR_SEC2: rd_val = {4'h2, sec_q[2].count};
         NFR_ADDR_SEC3: rd_val = {4'h3, sec_q[3].count};
         default: rd_val = 8'h00;
      endcase
   end
   always_comb begin
      st_d = st_q;
      sclk_d = sclk_s;
      bit_d = bit_q;
      sh_d = sh_q;
      op_d = op_q;
      addr_d = addr_q;
      tx_d = tx_q;
      miso_d = miso_q;
      prot_d = prot_q;
      conf_d = conf_q;
      stat_d = stat_q;
      sec_d = sec_q;
      busy_d = busy_q;
      acc_d = 1'b0;
      rej_d = 1'b0;
      // reset busy count; flag drops at zero
      if (busy_q != 16'h0) begin
         busy_d = busy_q - 16'h1;
         if (busy_q == 16'h1) begin
            stat_d[NFR_ST_OIP] = 1'b0;
         end
      end
      // array requests gated by protection
      if (i_array_req.valid) begin
         if (hit && span != '0) begin
            rej_d = 1'b1;
            if (i_array_req.is_erase) begin
               stat_d[NFR_ST_EFAIL] = 1'b1;
            end else begin
               stat_d[NFR_ST_PFAIL] = 1'b1;
            end
         end else begin
            acc_d = 1'b1;
         end
      end
      case (st_q)
         NFR_S_BOOT: begin
            // power-up defaults and strap capture after release
            prot_d = NFR_PR_RESET;
            conf_d = NFR_CF_RESET;
            conf_d[NFR_CF_OTPL] = i_otp_locked;
            stat_d = {2'b00, i_ecc_boot.summary, 4'h0};
            sec_d = i_ecc_boot.sector;
            st_d = NFR_S_IDLE;
         end
         NFR_S_IDLE: begin
            bit_d = 3'h0;
            if (!cs_n_s) begin
               st_d = NFR_S_OP;
            end
         end
         NFR_S_OP, NFR_S_ADDR, NFR_S_DATA: begin
            if (rise) begin
               sh_d = byte_in;
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  if (st_q == NFR_S_OP) begin
                     op_d = byte_in;
                     if (byte_in == NFR_OP_GET || byte_in == NFR_OP_SET) begin
                        st_d = NFR_S_ADDR;
                     end else if (byte_in == NFR_OP_RESET) begin
                        // reset keeps feature bits
                        stat_d = 8'h01;
                        // a same-cycle refusal keeps its fail flag
                        stat_d[NFR_ST_EFAIL] = rej_d && i_array_req.is_erase;
                        stat_d[NFR_ST_PFAIL] = rej_d && !i_array_req.is_erase;
                        sec_d = '0;
                        busy_d = 16'(RESET_BUSY_CYC);
                        st_d = NFR_S_SKIP;
                     end else begin
                        st_d = NFR_S_SKIP;
                     end
                  end else if (st_q == NFR_S_ADDR) begin
                     addr_d = byte_in;
                     st_d = NFR_S_DATA;
                  end else if (op_q == NFR_OP_SET) begin
                     case (addr_q)
                        NFR_ADDR_PROT: begin
                           if (prot_wr_ok) begin
                              prot_d = byte_in & NFR_PR_WMASK;
                           end
                        end
                        NFR_ADDR_CONF: begin
                           conf_d = (conf_q & ~NFR_CF_WMASK) |
                              (byte_in & NFR_CF_WMASK);
                           // otp lock only sets, never clears
                           conf_d[NFR_CF_OTPL] = conf_q[NFR_CF_OTPL] |
                              byte_in[NFR_CF_OTPL];
                        end
                        default: begin
                        end
                     endcase
                     st_d = NFR_S_SKIP;
                  end
               end
            end
            // a get feature loads the byte at the fall after the address
            if (st_q == NFR_S_DATA && op_q == NFR_OP_GET && fall) begin
               tx_d = (bit_q == 3'h0) ? {rd_val[6:0], 1'b0} :
                  {tx_q[6:0], 1'b0};
               miso_d = (bit_q == 3'h0) ? rd_val[7] : tx_q[7];
            end
            if (cs_n_s) begin
               st_d = NFR_S_IDLE;
            end
         end
         NFR_S_SKIP: begin
            if (cs_n_s) begin
               st_d = NFR_S_IDLE;
            end
         end
         default: st_d = NFR_S_IDLE;
      endcase
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         st_q <= NFR_S_BOOT;
         sclk_q <= 1'b0;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         op_q <= 8'h00;
         addr_q <= 8'h00;
         tx_q <= 8'h00;
         miso_q <= 1'b0;
         prot_q <= NFR_PR_RESET;
         conf_q <= NFR_CF_RESET;
         stat_q <= 8'h00;
         sec_q <= '0;
         busy_q <= 16'h0;
         acc_q <= 1'b0;
         rej_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sclk_q <= sclk_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         op_q <= op_d;
         addr_q <= addr_d;
         tx_q <= tx_d;
         miso_q <= miso_d;
         prot_q <= prot_d;
         conf_q <= conf_d;
         stat_q <= stat_d;
         sec_q <= sec_d;
         busy_q <= busy_d;
         acc_q <= acc_d;
         rej_q <= rej_d;
      end
   end
   assign o_miso = miso_q;
   assign o_miso_oe = (st_q == NFR_S_DATA) && (op_q == NFR_OP_GET) && !cs_n_s;
   assign o_protection = prot_q & NFR_PR_WMASK;
   assign o_configuration = conf_q & NFR_CF_WMASK;
   assign o_busy = stat_q[NFR_ST_OIP];
   assign o_array_accept = acc_q;
   assign o_array_reject = rej_q;
   // assertions
   property p_lock_freeze;
      @(posedge i_clock) disable iff (!i_rst_n)
      (st_q != NFR_S_BOOT && prot_q[NFR_PR_LOCK]) |=> $stable(prot_q);
   endproperty
   a_lock_freeze: assert property (p_lock_freeze)
      else $error("protection changed under lockdown");
   property p_gate_block;
      @(posedge i_clock) disable iff (!i_rst_n)
      (st_q != NFR_S_BOOT && !prot_q[NFR_PR_LOCK] && !conf_q[NFR_CF_QE] &&
         prot_q[NFR_PR_GATE] && !wp_n_s) |=> $stable(prot_q);
   endproperty
   a_gate_block: assert property (p_gate_block)
      else $error("protection writable with gate set and pin low");
   property p_quad_open;
      @(posedge i_clock) disable iff (!i_rst_n)
      (st_q == NFR_S_DATA && op_q == NFR_OP_SET && addr_q == NFR_ADDR_PROT &&
         rise && bit_q == 3'h7 && !prot_q[NFR_PR_LOCK] && conf_q[NFR_CF_QE])
         |=> (prot_q == ($past(byte_in) & NFR_PR_WMASK));
   endproperty
   a_quad_open: assert property (p_quad_open)
      else $error("protection blocked in quad mode");
   property p_boot_defaults;
      @(posedge i_clock) disable iff (!i_rst_n)
      (st_q == NFR_S_BOOT) |=> (prot_q == NFR_PR_RESET);
   endproperty
   a_boot_defaults: assert property (p_boot_defaults)
      else $error("protection default wrong after power up");
   property p_boot_conf;
      @(posedge i_clock) disable iff (!i_rst_n)
      (st_q == NFR_S_BOOT) |=> (conf_q[5:0] == NFR_CF_RESET[5:0]);
   endproperty
   a_boot_conf: assert property (p_boot_conf)
      else $error("configuration default wrong after power up");
   property p_reset_keeps;
      @(posedge i_clock) disable iff (!i_rst_n)
      (busy_q == 16'(RESET_BUSY_CYC)) |-> $stable(prot_q) && $stable(conf_q);
   endproperty
   a_reset_keeps: assert property (p_reset_keeps)
      else $error("reset command altered feature bits");
   property p_busy_ends;
      @(posedge i_clock) disable iff (!i_rst_n)
      (busy_q == 16'h1) |=> !stat_q[NFR_ST_OIP];
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("busy flag stuck after reset");
   property p_reset_clears;
      @(posedge i_clock) disable iff (!i_rst_n)
      (busy_q == 16'(RESET_BUSY_CYC)) |-> (sec_q == '0) &&
         (stat_q[7:1] == 7'h00 || $past(i_array_req.valid));
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("reset did not clear status");
   property p_reject;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_array_req.valid && hit && span != '0) |=> o_array_reject &&
         !o_array_accept;
   endproperty
   a_reject: assert property (p_reject)
      else $error("protected block accepted");
   property p_level_zero;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_array_req.valid && lvl == 4'h0) |=> o_array_accept;
   endproperty
   a_level_zero: assert property (p_level_zero)
      else $error("level zero protected a block");
endmodule

/* File: nfr_sync.sv */
// nfr_sync: three-stage synchroniser with agree-on-two filter
// assumes: input is asynchronous to i_clock
`timescale 1ns/1ps
module nfr_sync #(
   // pin level while idle, loaded at reset so no false edge follows
   parameter logic IDLE_LEVEL = 1'b0
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // pin
   input wire logic i_pin,
   // filtered level
   output logic o_level
);
   logic [2:0] sh_q, sh_d;
   logic lvl_q, lvl_d;

   always_comb begin
      sh_d = {sh_q[1:0], i_pin};
      lvl_d = lvl_q;
      // stage 0 feeds stage 1 only; stages 1 and 2 must agree
      if (sh_q[1] == sh_q[2]) begin
         lvl_d = sh_q[2];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sh_q <= {3{IDLE_LEVEL}};
         lvl_q <= IDLE_LEVEL;
      end else begin
         sh_q <= sh_d;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;
endmodule

/* File: test_nand_feature_regs_block_protect.sv */
// test_nand_feature_regs_block_protect: self-checking feature bank bench
// assumes: nfr_regs with nfr_host_model on the link, 250 MHz clock
`timescale 1ns/1ps
module test_nand_feature_regs_block_protect;
   import nfr_pkg::*;
   // long busy so polling really sees it high
   localparam int BUSY_CYC = 2000;
   logic clock, rst_n, sclk, cs_n, mosi, wp_n, miso, miso_oe, otp_locked;
   logic accept, reject, busy, oe, sel;
   logic [7:0] protection, configuration, rd;
   logic [3:0] lvl;
   nfr_ecc_result_t ecc_boot;
   nfr_array_req_t array_req;
   int mismatches, comparisons, cycles, n;
   int blks[6];

   nfr_regs #(.RESET_BUSY_CYC(BUSY_CYC)) dut (.i_clock(clock),
      .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
      .i_wp_n(wp_n), .o_miso(miso), .o_miso_oe(miso_oe),
      .i_otp_locked(otp_locked), .i_ecc_boot(ecc_boot),
      .i_array_req(array_req), .o_array_accept(accept),
      .o_array_reject(reject), .o_protection(protection),
      .o_configuration(configuration), .o_busy(busy));

   nfr_host_model host (.i_clock(clock), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // hang guard, about 40 percent above the expected run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [7:0] seen,
         input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic get(input logic [7:0] addr, input logic [7:0] exp);
      host.frame(NFR_OP_GET, addr, 8'h00, rd, oe);
      check("get", rd, exp);
   endtask

   task automatic set(input logic [7:0] addr, input logic [7:0] data);
      host.frame(NFR_OP_SET, addr, data, rd, oe);
   endtask

   task automatic arr(input logic er, input int blk, input logic exp);
      @(negedge clock);
      array_req = '{1'b1, er, blk[10:0]};
      @(negedge clock);
      array_req = '0;
      check("array", {6'h0, accept, reject}, {6'h0, ~exp, exp});
   endtask

   task automatic power_up();
      rst_n = 1'b0;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      repeat (8) @(negedge clock);
   endtask

   function automatic logic prot(logic [3:0] l, logic s, int blk);
      int m;
      if (l == 4'h0) return 1'b0;
      if (l[3:2] == 2'b11) return 1'b1;
      m = 1 << (int'(l) - 1);
      return s ? (blk < m) : (blk >= 2048 - m);
   endfunction

   initial begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      otp_locked = 1'b1;
      ecc_boot = {2'b01, 4'h3, 4'h2, 4'h1, 4'h5};
      array_req = '0;
      power_up();
      // power-up defaults
      check("prot", protection, 8'h7C);
      check("conf", configuration, 8'h90);
      get(NFR_ADDR_PROT, 8'h7C);
      check("oe", {7'h0, oe}, 8'h01);
      get(NFR_ADDR_CONF, 8'h90);
      get(NFR_ADDR_STAT, 8'h10);
      for (int i = 0; i < 4; i++) begin
         get(NFR_ADDR_SEC0 + 8'(4 * i),
            {2'b00, 2'(i), ecc_boot.sector[i].count});
      end
      arr(1'b1, 0, 1'b1);
      // reserved bit written as one has no effect
      set(NFR_ADDR_PROT, 8'h02);
      get(NFR_ADDR_PROT, 8'h00);
      arr(1'b0, 2047, 1'b0);
      // every level and select code at the region edges
      for (int c = 0; c < 32; c++) begin
         lvl = 4'(c);
         sel = c[4];
         set(NFR_ADDR_PROT, {1'b0, lvl, sel, 2'b00});
         check("prot", protection, {1'b0, lvl, sel, 2'b00});
         n = (lvl == 4'h0 || lvl[3:2] == 2'b11) ? 1 : 1 << (int'(lvl) - 1);
         blks = '{0, 2047, n - 1, n, 2047 - n, 2048 - n};
         foreach (blks[k]) begin
            arr(c[0], blks[k], prot(lvl, sel, blks[k]));
         end
      end
      // gate bit with the pin, then quad mode
      set(NFR_ADDR_PROT, 8'h80);
      wp_n = 1'b0;
      set(NFR_ADDR_PROT, 8'h88);
      get(NFR_ADDR_PROT, 8'h80);
      wp_n = 1'b1;
      set(NFR_ADDR_PROT, 8'h88);
      get(NFR_ADDR_PROT, 8'h88);
      set(NFR_ADDR_CONF, 8'h91);
      wp_n = 1'b0;
      set(NFR_ADDR_PROT, 8'h80);
      get(NFR_ADDR_PROT, 8'h80);
      wp_n = 1'b1;
      set(NFR_ADDR_CONF, 8'h90);
      // reset command: busy, polled with get feature only
      host.frame(NFR_OP_RESET, 8'h00, 8'h00, rd, oe);
      check("busy", {7'h0, busy}, 8'h01);
      get(NFR_ADDR_STAT, 8'h01);
      for (int k = 0; k < 10 && rd[0] !== 1'b0; k++) begin
         host.frame(NFR_OP_GET, NFR_ADDR_STAT, 8'h00, rd, oe);
      end
      check("status", rd, 8'h00);
      get(NFR_ADDR_PROT, 8'h80);
      get(NFR_ADDR_CONF, 8'h90);
      get(NFR_ADDR_SEC1, 8'h10);
      // erase into protected region is refused and flagged
      set(NFR_ADDR_PROT, 8'h78);
      arr(1'b1, 5, 1'b1);
      get(NFR_ADDR_STAT, 8'h04);
      // lockdown freezes until power cycle
      set(NFR_ADDR_PROT, 8'h01);
      set(NFR_ADDR_PROT, 8'h00);
      get(NFR_ADDR_PROT, 8'h01);
      otp_locked = 1'b0;
      power_up();
      check("prot", protection, 8'h7C);
      get(NFR_ADDR_CONF, 8'h10);
      finish_test();
   end
endmodule
